// *** ard_pkg.sv ***
// shared constants and types of the adc result dma engine
package ard_pkg;
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned CONV_PERIOD_NS  = 2380; // fastest conversion period, 2.38 us
  // longest allowed time per sample, rounded down to whole cycles
  localparam int unsigned CONV_PERIOD_CYC = (CONV_PERIOD_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned ACC_CYC         = 4;    // cycles per external access
  localparam int unsigned ADDR_W          = 24;
  localparam int unsigned RES_W           = 12;
  localparam int unsigned CHAN_W          = 4;
  localparam int unsigned FIFO_DEPTH      = 16;
  // control bit positions
  localparam int unsigned CTRL_B_DMA_BIT  = 6;
  localparam int unsigned CTRL_A_MDH_BIT  = 7;
  localparam int unsigned CTRL_A_MDL_BIT  = 6;
  localparam int unsigned CTRL_A_T2_BIT   = 1;
  localparam int unsigned CTRL_A_EXT_BIT  = 0;
  localparam logic [3:0]  CHAN_STOP       = 4'hf;
  localparam logic [23:0] SLOT_STEP       = 24'h00_0002;
  localparam logic [23:0] PTR_RST         = 24'h00_0000;
  localparam logic [7:0]  BYTE_RST        = 8'h00;

  typedef struct packed {
    logic [CHAN_W-1:0] chan;
    logic [RES_W-1:0]  result;
  } ard_sample_t;

  typedef enum logic [6:0] {
    SEQ_OFF   = 7'b000_0001,
    SEQ_RDCUR = 7'b000_0010,
    SEQ_RDNXT = 7'b000_0100,
    SEQ_ARM   = 7'b000_1000,
    SEQ_CONV  = 7'b001_0000,
    SEQ_FLUSH = 7'b010_0000,
    SEQ_DONE  = 7'b100_0000
  } ard_seq_t;

  typedef enum logic [4:0] {
    BUS_IDLE = 5'b0_0001,
    BUS_ALE  = 5'b0_0010,
    BUS_ADDR = 5'b0_0100,
    BUS_STRB = 5'b0_1000,
    BUS_HOLD = 5'b1_0000
  } ard_bus_t;
endpackage

// *** ard_fifo.sv ***
// sample fifo between adc result capture and external memory writer
`timescale 1ns/1ps
module ard_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  // full and empty come from the count so neither side can overrun
  assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_ready_i && out_valid_o;
  assign out_data_o  = mem[rd_q];

  // storage has no reset, only pointers and count do
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem[wr_q] <= in_data_i;
    end
  end

  // pointers wrap at depth, which need not be a power of two
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// *** ard_dma_engine.sv ***
// adc result dma engine: channel list walker and external memory writer
`timescale 1ns/1ps
module ard_dma_engine #(
  parameter int unsigned FIFO_DEPTH = ard_pkg::FIFO_DEPTH
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  adc_ctrl_a_i,
  input  wire logic [7:0]  adc_ctrl_b_i,
  input  wire logic [7:0]  dma_ptr_low_i,
  input  wire logic [7:0]  dma_ptr_mid_i,
  input  wire logic [7:0]  dma_ptr_page_i,
  input  wire logic        conv_sw_start_i,
  input  wire logic        timer2_tick_i,
  input  wire logic        ext_trigger_i,
  input  wire logic        adc_result_valid_i,
  input  wire logic [11:0] adc_result_i,
  input  wire logic        adc_done_clr_i,
  input  wire logic [7:0]  muxed_addr_data_port_i,
  output logic             adc_conv_start_o,
  output logic [3:0]       adc_chan_o,
  output logic             adc_done_flag_o,
  output logic             core_xmem_deny_o,
  output logic [7:0]       muxed_addr_data_port_o,
  output logic             muxed_addr_data_port_oe_n_o,
  output logic [7:0]       upper_addr_port_o,
  output logic             ale_o,
  output logic             rd_n_o,
  output logic             wr_n_o
);
  ard_pkg::ard_seq_t    seq_q;
  ard_pkg::ard_bus_t    bus_q;
  ard_pkg::ard_sample_t fifo_in;
  ard_pkg::ard_sample_t fifo_out;
  logic        dma_en;
  logic        dma_en_q;
  logic        powered;
  logic        trigger;
  logic [2:0]  ext_sync_q;
  logic        ext_lvl_q;
  logic        ext_rise;
  logic [23:0] rd_ptr_q;
  logic [23:0] wr_ptr_q;
  logic [23:0] bus_addr_q;
  logic [7:0]  bus_data_q;
  logic        bus_wr_q;
  logic        bus_lo_q;
  logic        rd_req_q;
  logic        rd_done_q;
  logic [7:0]  rd_data_q;
  logic [3:0]  cur_id_q;
  logic [3:0]  nxt_id_q;
  logic        fifo_push;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic        fifo_pop;
  logic        flush_ok;
  logic [23:0] rd_addr;
  logic [23:0] bus_next;

  // next slot address, shared by reads and pointer steps
  function automatic logic [23:0] next_slot(input logic [23:0] a);
    next_slot = a + ard_pkg::SLOT_STEP;
  endfunction

  assign dma_en  = adc_ctrl_b_i[ard_pkg::CTRL_B_DMA_BIT];
  assign powered = adc_ctrl_a_i[ard_pkg::CTRL_A_MDH_BIT] | adc_ctrl_a_i[ard_pkg::CTRL_A_MDL_BIT];
  assign trigger = conv_sw_start_i
                 | (adc_ctrl_a_i[ard_pkg::CTRL_A_T2_BIT] & timer2_tick_i)
                 | (adc_ctrl_a_i[ard_pkg::CTRL_A_EXT_BIT] & ext_rise);
  assign ext_rise = (ext_sync_q[1] == ext_sync_q[2]) && ext_sync_q[2] && !ext_lvl_q;
  assign fifo_in  = '{chan: cur_id_q, result: adc_result_i};
  assign fifo_push = (seq_q == ard_pkg::SEQ_CONV) && adc_result_valid_i;
  assign fifo_pop  = (bus_q == ard_pkg::BUS_HOLD) && bus_wr_q && bus_lo_q;
  assign flush_ok  = !fifo_out_valid && (bus_q == ard_pkg::BUS_IDLE) && !rd_req_q;
  // id reads hit the current slot first, afterwards always one slot ahead
  assign rd_addr   = (seq_q == ard_pkg::SEQ_RDCUR) ? rd_ptr_q : next_slot(rd_ptr_q);
  assign bus_next  = bus_addr_q + 24'h00_0001;

  // external trigger pin: three stages, level accepted when last two agree
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_sync_q <= 3'h0;
      ext_lvl_q  <= 1'b0;
    end else begin
      ext_sync_q <= {ext_sync_q[1:0], ext_trigger_i};
      if (ext_sync_q[1] == ext_sync_q[2]) begin
        ext_lvl_q <= ext_sync_q[2];
      end
    end
  end

  // bus ownership follows dma enable; core only loses the access
  // core keeps its timing, only access blocked
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dma_en_q         <= 1'b0;
      core_xmem_deny_o <= 1'b0;
    end else begin
      dma_en_q         <= dma_en;
      // dma_en_q covers a cycle launched in the edge where enable drops
      core_xmem_deny_o <= dma_en || dma_en_q || (bus_q != ard_pkg::BUS_IDLE);
    end
  end

  // sample fifo keeps conversion capture apart from memory stalls
  ard_fifo #(
    .WIDTH ($bits(ard_pkg::ard_sample_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (fifo_push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (fifo_in),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_out)
  );

  // sequencer: walk the channel list, pace conversions, detect the stop code
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seq_q            <= ard_pkg::SEQ_OFF;
      rd_ptr_q         <= ard_pkg::PTR_RST;
      rd_req_q         <= 1'b0;
      cur_id_q         <= 4'h0;
      nxt_id_q         <= 4'h0;
      adc_conv_start_o <= 1'b0;
      adc_chan_o       <= 4'h0;
    end else begin
      adc_conv_start_o <= 1'b0;
      if (rd_done_q) begin
        rd_req_q <= 1'b0;
      end
      // leaving dma mode aborts the walk
      if (!dma_en) begin
        seq_q    <= ard_pkg::SEQ_OFF;
        rd_req_q <= 1'b0;
      end else begin
        case (seq_q)
          ard_pkg::SEQ_OFF: begin
            if (!dma_en_q) begin
              rd_ptr_q <= {dma_ptr_page_i, dma_ptr_mid_i, dma_ptr_low_i};
              rd_req_q <= 1'b1;
              seq_q    <= ard_pkg::SEQ_RDCUR;
            end
          end
          ard_pkg::SEQ_RDCUR: begin
            if (rd_done_q) begin
              cur_id_q <= rd_data_q[7:4];
              rd_req_q <= (rd_data_q[7:4] != ard_pkg::CHAN_STOP);
              seq_q    <= (rd_data_q[7:4] == ard_pkg::CHAN_STOP) ? ard_pkg::SEQ_FLUSH
                                                                 : ard_pkg::SEQ_RDNXT;
            end
          end
          ard_pkg::SEQ_RDNXT: begin
            // all-ones next field: current slot is the repeated id
            // so it and the stop slot are never written
            if (rd_done_q) begin
              nxt_id_q <= rd_data_q[7:4];
              seq_q    <= (rd_data_q[7:4] == ard_pkg::CHAN_STOP) ? ard_pkg::SEQ_FLUSH
                                                                 : ard_pkg::SEQ_ARM;
            end
          end
          ard_pkg::SEQ_ARM: begin
            // stall here while the fifo is full rather than drop a sample
            if (trigger && powered && fifo_in_ready) begin
              adc_conv_start_o <= 1'b1;
              adc_chan_o       <= cur_id_q;
              seq_q            <= ard_pkg::SEQ_CONV;
            end
          end
          ard_pkg::SEQ_CONV: begin
            // result queued, step to the next slot
            if (adc_result_valid_i) begin
              cur_id_q <= nxt_id_q;
              rd_ptr_q <= next_slot(rd_ptr_q);
              rd_req_q <= 1'b1;
              seq_q    <= ard_pkg::SEQ_RDNXT;
            end
          end
          ard_pkg::SEQ_FLUSH: begin
            if (flush_ok) begin
              seq_q <= ard_pkg::SEQ_DONE;
            end
          end
          ard_pkg::SEQ_DONE: begin
            seq_q <= ard_pkg::SEQ_DONE;
          end
          default: begin
            seq_q <= ard_pkg::SEQ_OFF;
          end
        endcase
      end
    end
  end

  // completion flag; a set in the clear cycle wins
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      adc_done_flag_o <= 1'b0;
    end else if ((seq_q == ard_pkg::SEQ_FLUSH) && flush_ok && dma_en) begin
      adc_done_flag_o <= 1'b1;
    end else if (adc_done_clr_i) begin
      adc_done_flag_o <= 1'b0;
    end
  end

  // external cycle: ale, address, strobe, hold; fifo writes first
  // 24-bit address carried on both ports
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_q                       <= ard_pkg::BUS_IDLE;
      bus_addr_q                  <= ard_pkg::PTR_RST;
      bus_data_q                  <= ard_pkg::BYTE_RST;
      bus_wr_q                    <= 1'b0;
      bus_lo_q                    <= 1'b0;
      wr_ptr_q                    <= ard_pkg::PTR_RST;
      rd_done_q                   <= 1'b0;
      rd_data_q                   <= ard_pkg::BYTE_RST;
      ale_o                       <= 1'b0;
      rd_n_o                      <= 1'b1;
      wr_n_o                      <= 1'b1;
      muxed_addr_data_port_o      <= ard_pkg::BYTE_RST;
      muxed_addr_data_port_oe_n_o <= 1'b1;
      upper_addr_port_o           <= ard_pkg::BYTE_RST;
    end else begin
      rd_done_q <= 1'b0;
      case (bus_q)
        ard_pkg::BUS_IDLE: begin
          if (!dma_en_q) begin
            wr_ptr_q <= {dma_ptr_page_i, dma_ptr_mid_i, dma_ptr_low_i};
          end else if (fifo_out_valid || (rd_req_q && !rd_done_q)) begin
            // high byte keeps the id above the top result bits
            bus_wr_q   <= fifo_out_valid;
            bus_lo_q   <= 1'b0;
            bus_addr_q <= fifo_out_valid ? wr_ptr_q : rd_addr;
            bus_data_q <= {fifo_out.chan, fifo_out.result[11:8]};
            bus_q      <= ard_pkg::BUS_ALE;
            // strobe with low and page bytes presented
            ale_o                       <= 1'b1;
            muxed_addr_data_port_oe_n_o <= 1'b0;
            muxed_addr_data_port_o      <= fifo_out_valid ? wr_ptr_q[7:0] : rd_addr[7:0];
            upper_addr_port_o           <= fifo_out_valid ? wr_ptr_q[23:16] : rd_addr[23:16];
          end
        end
        ard_pkg::BUS_ALE: begin
          // middle byte follows the latched page byte
          ale_o             <= 1'b0;
          upper_addr_port_o <= bus_addr_q[15:8];
          bus_q             <= ard_pkg::BUS_ADDR;
        end
        ard_pkg::BUS_ADDR: begin
          // low port turns from address to data
          rd_n_o                      <= bus_wr_q;
          wr_n_o                      <= !bus_wr_q;
          muxed_addr_data_port_oe_n_o <= !bus_wr_q;
          muxed_addr_data_port_o      <= bus_wr_q ? bus_data_q : ard_pkg::BYTE_RST;
          bus_q                       <= ard_pkg::BUS_STRB;
        end
        ard_pkg::BUS_STRB: begin
          rd_n_o                      <= 1'b1;
          wr_n_o                      <= 1'b1;
          muxed_addr_data_port_oe_n_o <= 1'b1;
          rd_data_q                   <= muxed_addr_data_port_i;
          bus_q                       <= ard_pkg::BUS_HOLD;
        end
        ard_pkg::BUS_HOLD: begin
          rd_done_q <= !bus_wr_q;
          if (bus_wr_q && !bus_lo_q) begin
            // second byte of the slot carries the low result bits
            bus_lo_q                    <= 1'b1;
            bus_addr_q                  <= bus_next;
            bus_data_q                  <= fifo_out.result[7:0];
            ale_o                       <= 1'b1;
            muxed_addr_data_port_oe_n_o <= 1'b0;
            muxed_addr_data_port_o      <= bus_next[7:0];
            upper_addr_port_o           <= bus_next[23:16];
            bus_q                       <= ard_pkg::BUS_ALE;
          end else begin
            if (bus_wr_q) begin
              wr_ptr_q <= next_slot(wr_ptr_q);
            end
            bus_q <= ard_pkg::BUS_IDLE;
          end
        end
        default: begin
          bus_q <= ard_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  a_strobe_owned: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (ale_o || !wr_n_o || !rd_n_o) |-> core_xmem_deny_o)
    else $error("external cycle without bus ownership");

  a_cycle_shape: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(ale_o) |=> !ale_o ##1 (rd_n_o ^ wr_n_o) ##1 (rd_n_o && wr_n_o))
    else $error("external cycle phases out of order");

  a_ale_bytes: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    ale_o |-> (muxed_addr_data_port_o == bus_addr_q[7:0])
           && (upper_addr_port_o == bus_addr_q[23:16]) && !muxed_addr_data_port_oe_n_o)
    else $error("low or page byte wrong at address strobe");

  a_write_data: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !wr_n_o |-> !muxed_addr_data_port_oe_n_o && (muxed_addr_data_port_o == bus_data_q)
             && (upper_addr_port_o == bus_addr_q[15:8]))
    else $error("write data or middle byte wrong");

  a_start_ptr: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (seq_q == ard_pkg::SEQ_OFF && dma_en && !dma_en_q) |=>
      rd_ptr_q == {$past(dma_ptr_page_i), $past(dma_ptr_mid_i), $past(dma_ptr_low_i)})
    else $error("walk did not start at loaded pointer");

  a_ptr_step: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (fifo_push && dma_en) |=> rd_ptr_q == $past(rd_ptr_q) + ard_pkg::SLOT_STEP)
    else $error("pointer did not step by one slot");

  a_stop_code: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (seq_q == ard_pkg::SEQ_RDNXT && rd_done_q && dma_en
      && rd_data_q[7:4] == ard_pkg::CHAN_STOP) |=> !adc_conv_start_o [*3])
    else $error("conversion started after stop code");

  a_done_set: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (seq_q == ard_pkg::SEQ_FLUSH && flush_ok && dma_en) |=> adc_done_flag_o)
    else $error("done flag not set at completion");

  a_mode_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    adc_conv_start_o |-> $past(dma_en) && $past(seq_q == ard_pkg::SEQ_ARM))
    else $error("conversion outside dma mode");

  a_drain_fast: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (bus_q == ard_pkg::BUS_IDLE && fifo_out_valid && dma_en_q) |=> ##[0:9] fifo_pop)
    else $error("sample store slower than conversion rate");
endmodule

// *** ard_sram_model.sv ***
// external static ram on the multiplexed data-memory bus
`timescale 1ns/1ps
module ard_sram_model (
  input  wire logic       sys_clk_i,
  input  wire logic       ale_i,
  input  wire logic       oe_n_i,
  input  wire logic       rd_n_i,
  input  wire logic       wr_n_i,
  input  wire logic [7:0] port_i,
  input  wire logic [7:0] upper_i,
  output logic      [7:0] data_o,
  output logic            drive_o
);
  logic [7:0]  mem [logic [23:0]];
  logic [23:0] addr_q;
  logic        ale_q;
  logic        hold_q;

  // latch low and page bytes at the strobe, middle byte one cycle later
  always @(posedge sys_clk_i) begin
    ale_q <= ale_i;
    hold_q <= !rd_n_i;
    if (ale_i) begin
      addr_q[7:0] <= port_i;
      addr_q[23:16] <= upper_i;
    end
    if (ale_q) begin
      addr_q[15:8] <= upper_i;
    end
    // write only while the engine drives the low port
    if (!wr_n_i && !oe_n_i) begin
      mem[addr_q] = port_i;
    end
  end

  // read data holds one cycle past the strobe, then the pull-ups take the port
  always @* begin
    drive_o = !rd_n_i || hold_q;
    data_o = 8'hff;
    if (drive_o) begin
      data_o = mem.exists(addr_q) ? mem[addr_q] : 8'h5a;
    end
  end
endmodule

// *** testbench.sv ***
// self-checking bench for the adc result dma engine
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module testbench;
  logic        sys_clk_i, rst_n_i, sw, t2, ext, rv, clr, trig_en;
  logic [7:0]  ctrl_a, ctrl_b, p_lo, p_mid, p_pg, port_o, port_in, upper, sram_d;
  logic [11:0] res;
  logic [3:0]  chan, a_ch;
  logic        start, done, deny, oe_n, ale, rd_n, wr_n, drv;
  int          bad_count, n_compared, cyc, a_cnt, last_st, mode;
  integer      seed;
  ard_pkg::ard_sample_t exp_q[$];

  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  ard_dma_engine i_dut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .adc_ctrl_a_i(ctrl_a), .adc_ctrl_b_i(ctrl_b),
    .dma_ptr_low_i(p_lo), .dma_ptr_mid_i(p_mid), .dma_ptr_page_i(p_pg),
    .conv_sw_start_i(sw), .timer2_tick_i(t2), .ext_trigger_i(ext),
    .adc_result_valid_i(rv), .adc_result_i(res), .adc_done_clr_i(clr),
    .muxed_addr_data_port_i(port_in), .adc_conv_start_o(start), .adc_chan_o(chan),
    .adc_done_flag_o(done), .core_xmem_deny_o(deny), .muxed_addr_data_port_o(port_o),
    .muxed_addr_data_port_oe_n_o(oe_n), .upper_addr_port_o(upper), .ale_o(ale),
    .rd_n_o(rd_n), .wr_n_o(wr_n)
  );

  ard_sram_model i_sram (
    .sys_clk_i(sys_clk_i), .ale_i(ale), .oe_n_i(oe_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
    .port_i(port_o), .upper_i(upper), .data_o(sram_d), .drive_o(drv)
  );

  // low port level: engine, else ram, else the strong pull-ups
  assign port_in = !oe_n ? port_o : (drv ? sram_d : 8'hff);

  // adc stand-in and trigger sources; only this process draws from the seed at rising edges
  always @(posedge sys_clk_i) begin
    int x;
    x = $random(seed);
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      final_report();
    end
    sw <= trig_en && mode == 0 && !sw;
    t2 <= trig_en && mode == 1 && x[2:0] == 3'h0;
    ext <= trig_en && mode == 2 && x[3];
    rv <= a_cnt == 1;
    a_cnt <= (a_cnt > 0) ? a_cnt - 1 : 0;
    if (a_cnt == 1) begin
      res <= x[15:4];
      exp_q.push_back({a_ch, x[15:4]});
    end
    if (start) begin
      a_ch <= chan;
      a_cnt <= 8;
      if (mode == 0 && last_st > 0) `CHK(cyc - last_st <= ard_pkg::CONV_PERIOD_CYC, 1'b1)
      last_st <= cyc;
    end
    if (!trig_en) begin
      last_st <= 0;
    end
  end

  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // one list walk: prepare ram, arm the engine, check the stored image
  task automatic run(input int m, input int n);
    logic [23:0] b;
    logic [7:0]  v;
    logic [7:0]  img[$];
    int          k;
    @(negedge sys_clk_i);
    b = {1'b0, 23'($random(seed))};
    // ids every second byte, last id repeated, then the stop code
    for (k = 0; k < 2 * n + 6; k++) begin
      v = 8'($random(seed));
      if (k % 2 == 0) begin
        v[7:4] = 4'($random(seed)) % 4'hf;
        if (k == 2 * n) begin
          v[7:4] = (n == 0) ? 4'hf : img[k-2][7:4];
        end
        if (k == 2 * n + 2) begin
          v[7:4] = 4'hf;
        end
      end
      img.push_back(v);
      i_sram.mem[b + 24'(k)] = v;
    end
    @(posedge sys_clk_i);
    mode <= m;
    ctrl_a <= 8'h00;
    p_lo <= b[7:0];
    @(posedge sys_clk_i);
    p_mid <= b[15:8];
    @(posedge sys_clk_i);
    p_pg <= b[23:16];
    @(posedge sys_clk_i);
    ctrl_b <= 8'h40;
    @(posedge sys_clk_i);
    // no temperature input here, so any conversion clock will do
    ctrl_a <= 8'hc0 | (m == 1 ? 8'h02 : (m == 2 ? 8'h01 : 8'h00));
    trig_en <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    `CHK(deny, 1'b1)
    k = 0;
    while (done !== 1'b1 && k < 4000) begin
      @(posedge sys_clk_i);
      k++;
    end
    `CHK(done, 1'b1)
    `CHK(exp_q.size(), n)
    for (k = 0; k < 2 * n + 6; k++) begin
      if (k >= 2 * n) begin
        `CHK(i_sram.mem[b + 24'(k)], img[k])
      end else if (k % 2 == 0) begin
        `CHK(exp_q[k/2].chan, img[k][7:4])
        `CHK(i_sram.mem[b + 24'(k)], {img[k][7:4], exp_q[k/2].result[11:8]})
      end else begin
        `CHK(i_sram.mem[b + 24'(k)], exp_q[k/2].result[7:0])
      end
    end
    trig_en <= 1'b0;
    ctrl_b <= 8'h00;
    clr <= 1'b1;
    @(posedge sys_clk_i);
    clr <= 1'b0;
    repeat (20) @(posedge sys_clk_i);
    `CHK(done, 1'b0)
    `CHK(deny, 1'b0)
    exp_q.delete();
    $display("test mode %0d with %0d samples done", m, n);
  endtask

  initial begin
    seed = 32'haf87_0e7e;
    {rst_n_i, sw, t2, ext, rv, clr, trig_en} = '0;
    {ctrl_a, ctrl_b, p_lo, p_mid, p_pg, res} = '0;
    {bad_count, n_compared, cyc, a_cnt, last_st, mode} = '0;
    repeat (5) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    // short and long lists under every pacing source, the one empty list under timer 2 pacing
    for (int t = 0; t < 8; t++) begin
      run(t % 3, (t == 7) ? 0 : (t * 5 + 1) % 9);
    end
    final_report();
  end
endmodule
